// ### pkg/rovt_defs.svh
// register map, field positions, reset values and timing constants
`ifndef ROVT_DEFS_SVH
`define ROVT_DEFS_SVH

`define ROVT_ADDR_CTRL 8'h00
`define ROVT_ADDR_THRESH 8'h04
`define ROVT_ADDR_DELAY 8'h08
`define ROVT_ADDR_STATUS 8'h0C
`define ROVT_ADDR_IRQ_STAT 8'h10
`define ROVT_ADDR_IRQ_MASK 8'h14
`define ROVT_ADDR_ELAPSED 8'h18

`define ROVT_CTRL_OPER_BIT 0
`define ROVT_CTRL_STONLY_BIT 1

`define ROVT_STAT_FSM_LSB 0
`define ROVT_STAT_START_BIT 2
`define ROVT_STAT_TRIP_BIT 3
`define ROVT_STAT_GENST_BIT 4
`define ROVT_STAT_GENTR_BIT 5

`define ROVT_IRQ_START_BIT 0
`define ROVT_IRQ_TRIP_BIT 1
`define ROVT_IRQ_DROP_BIT 2

`define ROVT_OPER_RST 1'b1
`define ROVT_STONLY_RST 1'b0
`define ROVT_THR_RST 8'h1E
`define ROVT_THR_MIN 8'h02
`define ROVT_THR_MAX 8'h3C
`define ROVT_DLY_RST 16'h0064
`define ROVT_DLY_MAX 16'hEA60
`define ROVT_MASK_RST 3'h0

`define ROVT_RESP_OKAY 2'h0
`define ROVT_RESP_SLVERR 2'h2

`define ROVT_CLK_PERIOD_NS 8
`define ROVT_MS_NS 1000000
`define ROVT_CYC_PER_MS (`ROVT_MS_NS / `ROVT_CLK_PERIOD_NS)

`endif

// ### pkg/rovt_pkg.sv
// types shared by the residual overvoltage trip block
package rovt_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rovt_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rovt_axi_rsp_t;

  typedef enum logic [1:0] {
    ROVT_IDLE = 2'b00,
    ROVT_TIMING = 2'b01,
    ROVT_TRIPPED = 2'b11
  } rovt_fsm_t;

  typedef struct packed {
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic oper;
    logic st_only;
    logic [7:0] thr;
    logic [15:0] dly;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    rovt_fsm_t fsm;
    logic [31:0] pre;
    logic [15:0] ms_cnt;
    logic start;
    logic trip;
    logic gen_st;
    logic gen_tr;
  } rovt_state_t;

endpackage

// ### design/rovt_top.sv
// residual overvoltage definite-time start/trip decision with AXI4-Lite regs
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "rovt_defs.svh"

module rovt_top #(
  parameter int MAG_W = 8,
  parameter int CYC_PER_MS = `ROVT_CYC_PER_MS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rovt_pkg::rovt_axi_req_t axi_req_i,
  output rovt_pkg::rovt_axi_rsp_t axi_rsp_o,
  input wire logic [MAG_W-1:0] residual_voltage_magnitude_i,
  input wire logic block_input_i,
  output logic internal_start_flag_o,
  output logic internal_trip_flag_o,
  output logic general_start_out_o,
  output logic general_trip_out_o,
  output logic irq_o
);
  import rovt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state register

  rovt_state_t state_ff;
  rovt_state_t nxt_state;

  localparam rovt_state_t RST_STATE = '{
    aw_hold: 1'b0,
    aw_addr: 8'h00,
    w_hold: 1'b0,
    w_data: 32'h0000_0000,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: `ROVT_RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: `ROVT_RESP_OKAY,
    oper: `ROVT_OPER_RST,
    st_only: `ROVT_STONLY_RST,
    thr: `ROVT_THR_RST,
    dly: `ROVT_DLY_RST,
    irq_stat: 3'h0,
    irq_mask: `ROVT_MASK_RST,
    fsm: ROVT_IDLE,
    pre: 32'h0000_0000,
    ms_cnt: 16'h0000,
    start: 1'b0,
    trip: 1'b0,
    gen_st: 1'b0,
    gen_tr: 1'b0
  };

  // prescaler wraps once per millisecond of definite delay
  localparam logic [31:0] PRE_LAST = 32'(CYC_PER_MS - 1);

  // synchronous reset restores the setting defaults
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff <= RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    // lanes without a strobe keep their old contents
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // out-of-range settings saturate rather than wrap
  function automatic logic [7:0] clamp_thr(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v < `ROVT_THR_MIN) begin
      r = `ROVT_THR_MIN;
    end else if (v > `ROVT_THR_MAX) begin
      r = `ROVT_THR_MAX;
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp_dly(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (v > `ROVT_DLY_MAX) begin
      r = `ROVT_DLY_MAX;
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(
    input logic oper,
    input logic st_only
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ROVT_CTRL_OPER_BIT] = oper;
    w[`ROVT_CTRL_STONLY_BIT] = st_only;
    return w;
  endfunction

  function automatic logic [31:0] status_word(input rovt_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ROVT_STAT_FSM_LSB +: 2] = s.fsm;
    w[`ROVT_STAT_START_BIT] = s.start;
    w[`ROVT_STAT_TRIP_BIT] = s.trip;
    w[`ROVT_STAT_GENST_BIT] = s.gen_st;
    w[`ROVT_STAT_GENTR_BIT] = s.gen_tr;
    return w;
  endfunction

  // one bit per event: general start rise, general trip rise, start fall
  function automatic logic [2:0] irq_events(
    input rovt_state_t nx,
    input rovt_state_t cu
  );
    logic [2:0] e;
    e = 3'h0;
    e[`ROVT_IRQ_START_BIT] = nx.gen_st & ~cu.gen_st;
    e[`ROVT_IRQ_TRIP_BIT] = nx.gen_tr & ~cu.gen_tr;
    e[`ROVT_IRQ_DROP_BIT] = ~nx.gen_st & cu.gen_st;
    return e;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // handshake outputs

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;

  // write channels refuse while their beat is held or the response waits,
  // so a new write cannot overrun an unaccepted response
  assign aw_take = axi_req_i.awvalid & ~state_ff.aw_hold & ~state_ff.bvalid;
  assign w_take = axi_req_i.wvalid & ~state_ff.w_hold & ~state_ff.bvalid;
  // the read channel refuses while read data still waits
  assign ar_take = axi_req_i.arvalid & ~state_ff.rvalid;
  assign do_write = state_ff.aw_hold & state_ff.w_hold;

  assign axi_rsp_o.awready = ~state_ff.aw_hold & ~state_ff.bvalid;
  assign axi_rsp_o.wready = ~state_ff.w_hold & ~state_ff.bvalid;
  assign axi_rsp_o.bvalid = state_ff.bvalid;
  assign axi_rsp_o.bresp = state_ff.bresp;
  assign axi_rsp_o.arready = ~state_ff.rvalid;
  assign axi_rsp_o.rvalid = state_ff.rvalid;
  assign axi_rsp_o.rdata = state_ff.rdata;
  assign axi_rsp_o.rresp = state_ff.rresp;

  assign internal_start_flag_o = state_ff.start;
  assign internal_trip_flag_o = state_ff.trip;
  assign general_start_out_o = state_ff.gen_st;
  assign general_trip_out_o = state_ff.gen_tr;
  assign irq_o = |(state_ff.irq_stat & state_ff.irq_mask);

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic above;
    logic enable;
    logic [31:0] wval;
    logic [31:0] cur;
    logic [2:0] ev;
    logic rd_clr;
    above = 1'b0;
    enable = 1'b0;
    wval = 32'h0000_0000;
    cur = 32'h0000_0000;
    ev = 3'h0;
    rd_clr = 1'b0;
    nxt_state = state_ff;

    // write channel capture, either order
    if (aw_take) begin
      nxt_state.aw_hold = 1'b1;
      nxt_state.aw_addr = axi_req_i.awaddr;
    end
    if (w_take) begin
      nxt_state.w_hold = 1'b1;
      nxt_state.w_data = axi_req_i.wdata;
      nxt_state.w_strb = axi_req_i.wstrb;
    end
    if (state_ff.bvalid && axi_req_i.bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // both beats held: commit the word and raise the response
    if (do_write) begin
      nxt_state.aw_hold = 1'b0;
      nxt_state.w_hold = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `ROVT_RESP_OKAY;
      unique case (state_ff.aw_addr)
        `ROVT_ADDR_CTRL: begin
          cur = ctrl_word(state_ff.oper, state_ff.st_only);
          wval = merge_bytes(cur, state_ff.w_data, state_ff.w_strb);
          nxt_state.oper = wval[`ROVT_CTRL_OPER_BIT];
          nxt_state.st_only = wval[`ROVT_CTRL_STONLY_BIT];
        end
        `ROVT_ADDR_THRESH: begin
          cur = {24'h00_0000, state_ff.thr};
          wval = merge_bytes(cur, state_ff.w_data, state_ff.w_strb);
          nxt_state.thr = clamp_thr(wval[7:0]);
        end
        `ROVT_ADDR_DELAY: begin
          cur = {16'h0000, state_ff.dly};
          wval = merge_bytes(cur, state_ff.w_data, state_ff.w_strb);
          nxt_state.dly = clamp_dly(wval[15:0]);
        end
        `ROVT_ADDR_IRQ_MASK: begin
          cur = {29'h0000_0000, state_ff.irq_mask};
          wval = merge_bytes(cur, state_ff.w_data, state_ff.w_strb);
          nxt_state.irq_mask = wval[2:0];
        end
        `ROVT_ADDR_STATUS,
        `ROVT_ADDR_IRQ_STAT,
        `ROVT_ADDR_ELAPSED: begin
          // read-only: write is ignored
        end
        default: begin
          nxt_state.bresp = `ROVT_RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (state_ff.rvalid && axi_req_i.rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = `ROVT_RESP_OKAY;
      nxt_state.rdata = 32'h0000_0000;
      unique case (axi_req_i.araddr)
        `ROVT_ADDR_CTRL: begin
          nxt_state.rdata = ctrl_word(state_ff.oper, state_ff.st_only);
        end
        `ROVT_ADDR_THRESH: begin
          nxt_state.rdata[7:0] = state_ff.thr;
        end
        `ROVT_ADDR_DELAY: begin
          nxt_state.rdata[15:0] = state_ff.dly;
        end
        `ROVT_ADDR_STATUS: begin
          nxt_state.rdata = status_word(state_ff);
        end
        `ROVT_ADDR_IRQ_STAT: begin
          // the answer carries the events; the register clears behind it
          nxt_state.rdata[2:0] = state_ff.irq_stat;
          rd_clr = 1'b1;
        end
        `ROVT_ADDR_IRQ_MASK: begin
          nxt_state.rdata[2:0] = state_ff.irq_mask;
        end
        `ROVT_ADDR_ELAPSED: begin
          nxt_state.rdata[15:0] = state_ff.ms_cnt;
        end
        default: begin
          nxt_state.rresp = `ROVT_RESP_SLVERR;
        end
      endcase
    end

    // protection decision; magnitude is the residual fundamental RMS
    // a magnitude equal to the threshold does not start
    above = residual_voltage_magnitude_i > MAG_W'(state_ff.thr);
    // operation off or the block input hold the function idle; the
    // flags drop one edge after either appears
    enable = state_ff.oper & ~block_input_i & above;

    unique case (state_ff.fsm)
      ROVT_IDLE: begin
        nxt_state.pre = 32'h0000_0000;
        nxt_state.ms_cnt = 16'h0000;
        nxt_state.trip = 1'b0;
        nxt_state.start = 1'b0;
        if (enable) begin
          nxt_state.fsm = ROVT_TIMING;
          nxt_state.start = 1'b1;
        end
      end
      ROVT_TIMING: begin
        if (!enable) begin
          nxt_state.fsm = ROVT_IDLE;
          nxt_state.start = 1'b0;
          nxt_state.trip = 1'b0;
          nxt_state.pre = 32'h0000_0000;
          nxt_state.ms_cnt = 16'h0000;
        end else if (state_ff.ms_cnt >= state_ff.dly) begin
          // live compare: a lowered delay trips at the next edge
          nxt_state.fsm = ROVT_TRIPPED;
          nxt_state.trip = 1'b1;
        end else if (state_ff.pre == PRE_LAST) begin
          nxt_state.pre = 32'h0000_0000;
          nxt_state.ms_cnt = state_ff.ms_cnt + 16'h0001;
        end else begin
          nxt_state.pre = state_ff.pre + 32'h0000_0001;
        end
      end
      ROVT_TRIPPED: begin
        // trip holds until the start condition goes away
        if (!enable) begin
          nxt_state.fsm = ROVT_IDLE;
          nxt_state.start = 1'b0;
          nxt_state.trip = 1'b0;
          nxt_state.pre = 32'h0000_0000;
          nxt_state.ms_cnt = 16'h0000;
        end
      end
      default: begin
        nxt_state.fsm = ROVT_IDLE;
        nxt_state.start = 1'b0;
        nxt_state.trip = 1'b0;
      end
    endcase

    // qualified general outputs; start-only keeps the internal trip
    // but withholds the general trip
    nxt_state.gen_st = nxt_state.start;
    nxt_state.gen_tr = nxt_state.trip & ~state_ff.st_only;

    // sticky events; a new event wins over the read clear
    ev = irq_events(nxt_state, state_ff);
    if (rd_clr) begin
      nxt_state.irq_stat = ev;
    end else begin
      nxt_state.irq_stat = state_ff.irq_stat | ev;
    end
  end

endmodule

// ### verification/rovt_top_asserts.sv
// concurrent checks on the residual overvoltage trip block ports
`timescale 1ns/1ps
module rovt_top_asserts #(
  parameter int MAG_W = 8,
  parameter int CYC_PER_MS = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rovt_pkg::rovt_axi_req_t axi_req_i,
  input wire rovt_pkg::rovt_axi_rsp_t axi_rsp_o,
  input wire logic [MAG_W-1:0] residual_voltage_magnitude_i,
  input wire logic block_input_i,
  input wire logic internal_start_flag_o,
  input wire logic internal_trip_flag_o,
  input wire logic general_start_out_o,
  input wire logic general_trip_out_o,
  input wire logic irq_o
);
  import rovt_pkg::*;
  wire logic st = internal_start_flag_o;
  wire logic tr = internal_trip_flag_o;
  wire logic gs = general_start_out_o;
  wire logic gt = general_trip_out_o;
  wire logic [MAG_W-1:0] mag = residual_voltage_magnitude_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_ar_taken;
    axi_req_i.arvalid && axi_rsp_o.arready;
  endsequence
  sequence s_b_wait;
    axi_rsp_o.bvalid && !axi_req_i.bready;
  endsequence
  chk_block_quiet: assert property (block_input_i |=> !st && !tr)
    else $error("flag set under block");
  chk_gen_start: assert property (gs == st)
    else $error("general start differs");
  chk_gen_trip: assert property (gt |-> tr)
    else $error("general trip without trip");
  chk_trip_start: assert property (tr |-> st)
    else $error("trip without start");
  chk_rise_order: assert property ($rose(st) |-> !tr)
    else $error("trip together with start");
  chk_drop_all: assert property ($fell(st) |-> !tr && !gt)
    else $error("trip outlives start");
  chk_zero_drop: assert property (mag == '0 |=> !st)
    else $error("start at zero voltage");
  chk_read_answer: assert property (s_ar_taken |=> axi_rsp_o.rvalid)
    else $error("read not answered");
  chk_resp_stands: assert property (s_b_wait |=> axi_rsp_o.bvalid)
    else $error("write response dropped");
endmodule

bind rovt_top rovt_top_asserts #(.MAG_W(MAG_W), .CYC_PER_MS(CYC_PER_MS))
  rovt_top_asserts_i (.ref_clk_i, .rst_i, .axi_req_i, .axi_rsp_o,
  .residual_voltage_magnitude_i, .block_input_i, .internal_start_flag_o,
  .internal_trip_flag_o, .general_start_out_o, .general_trip_out_o,
  .irq_o);

// ### verification/rovt_mag_src.sv
// upstream stage model: registered residual voltage magnitude
`timescale 1ns/1ps
module rovt_mag_src #(
  parameter int MAG_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [MAG_W-1:0] level_i,
  output logic [MAG_W-1:0] mag_o
);
  // one fresh fundamental rms value of 3Uo per clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mag_o <= '0;
    end else begin
      mag_o <= level_i;
    end
  end
endmodule

// ### verification/residual_overvoltage_trip_bench.sv
// self-checking bench for the residual overvoltage trip block
`timescale 1ns/1ps
module residual_overvoltage_trip_bench;
  import rovt_pkg::*;
  logic clk, rst, blk, st, tr, gst, gtr, irq;
  logic [7:0] lvl, mag;
  rovt_axi_req_t rq;
  rovt_axi_rsp_t rs;
  logic [31:0] d;
  logic [1:0] r, br;
  int n_fail, comparisons, cyc, n;
  rovt_mag_src rovt_mag_src_i (.ref_clk_i(clk), .rst_i(rst), .level_i(lvl),
    .mag_o(mag));
  rovt_top #(.CYC_PER_MS(4)) rovt_top_i (.ref_clk_i(clk), .rst_i(rst),
    .axi_req_i(rq), .axi_rsp_o(rs), .residual_voltage_magnitude_i(mag),
    .block_input_i(blk), .internal_start_flag_o(st),
    .internal_trip_flag_o(tr), .general_start_out_o(gst),
    .general_trip_out_o(gtr), .irq_o(irq));
  always #4 clk = ~clk;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  // readies are looked at mid-cycle; they only move after a rising edge
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge clk);
    rq <= {1'b1, a, 1'b1, v, 4'hF, 1'b0, 1'b0, 8'h00, 1'b0};
    do begin
      @(negedge clk);
      ta = rs.awready && rq.awvalid;
      tw = rs.wready && rq.wvalid;
      @(posedge clk);
      if (ta) rq.awvalid <= 1'b0;
      if (tw) rq.wvalid <= 1'b0;
    end while ((rq.awvalid && !ta) || (rq.wvalid && !tw));
    // bready rises only once bvalid stands, so the response must wait
    do begin
      @(negedge clk);
      ta = rs.bvalid;
      br = rs.bresp;
      @(posedge clk);
    end while (!ta);
    rq.bready <= 1'b1;
    @(posedge clk);
    rq.bready <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic t;
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(negedge clk);
      t = rs.arready;
      @(posedge clk);
    end while (!t);
    rq.arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = rs.rvalid;
      d = rs.rdata;
      r = rs.rresp;
      @(posedge clk);
    end while (!t);
    rq.rready <= 1'b0;
    chk(nm, d, e);
  endtask
  task drv(input logic [7:0] v, input logic b);
    @(posedge clk);
    lvl <= v;
    blk <= b;
  endtask
  task flags(input logic [3:0] e);
    chk("st_tr_gst_gtr", {st, tr, gst, gtr}, e);
  endtask
  task wait_st;
    n = 0;
    while (st !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  task cnt_tr;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tr !== 1'b1 && n < 50);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    blk = 1'b0;
    lvl = 8'h00;
    rq = '0;
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl", 8'h00, 32'h1);
    rdc("thr", 8'h04, 32'h1E);
    rdc("dly", 8'h08, 32'h64);
    rdc("mask", 8'h14, 32'h0);
    rdc("unmapped", 8'h1C, 32'h0);
    chk("unmapped_resp", r, 32'h2);
    wr(8'h04, 32'h64);
    chk("wr_resp", br, 32'h0);
    rdc("thr_hi", 8'h04, 32'h3C);
    wr(8'h04, 32'h0);
    rdc("thr_lo", 8'h04, 32'h2);
    wr(8'h08, 32'hFFFF);
    rdc("dly_hi", 8'h08, 32'hEA60);
    wr(8'h1C, 32'h5);
    chk("wr_unmapped_resp", br, 32'h2);
    wr(8'h0C, 32'h0);
    chk("wr_ro_resp", br, 32'h0);
    $display("test registers done");
    wr(8'h04, 32'h1E);
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h7);
    rdc("mask_rd", 8'h14, 32'h7);
    drv(8'h1E, 1'b0);
    repeat (4) @(negedge clk);
    flags(4'h0);
    drv(8'h1F, 1'b0);
    wait_st;
    flags(4'hA);
    cnt_tr;
    chk("delay", n, 32'h9);
    flags(4'hF);
    chk("irq", irq, 32'h1);
    drv(8'h1E, 1'b0);
    repeat (3) @(negedge clk);
    flags(4'h0);
    rdc("irq_stat", 8'h10, 32'h7);
    rdc("irq_clear", 8'h10, 32'h0);
    @(negedge clk);
    chk("irq_low", irq, 32'h0);
    $display("test timing done");
    wr(8'h00, 32'h3);
    drv(8'h28, 1'b0);
    wait_st;
    cnt_tr;
    flags(4'hE);
    rdc("status", 8'h0C, 32'h1F);
    rdc("elapsed", 8'h18, 32'h2);
    drv(8'h00, 1'b0);
    wr(8'h00, 32'h1);
    drv(8'h28, 1'b1);
    repeat (12) @(negedge clk);
    flags(4'h0);
    drv(8'h28, 1'b0);
    wait_st;
    flags(4'hA);
    drv(8'h00, 1'b0);
    wr(8'h00, 32'h0);
    drv(8'h28, 1'b0);
    repeat (12) @(negedge clk);
    flags(4'h0);
    $display("test modes done");
    test_done;
  end
endmodule
